// ==== src/swm_pkg.sv ====
`default_nettype none
package swm_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] OFF_SYS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFF_SYS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFF_CLOCK_GATE   = 8'h08;
    localparam logic [7:0] OFF_STATUS       = 8'h0C;

    // values after reset
    localparam logic [7:0] CTRL_ONE_RST     = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST     = 8'h00;
    localparam logic [7:0] CLOCK_GATE_RST   = 8'hFF;

    // field positions
    localparam int         MEDIUM_SPEED_BIT = 0;
    localparam int         LVD_GATE_BIT     = 7;
    localparam logic [7:0] GATE_RSVD_MASK   = 8'h60;
    localparam int         NUM_PERIPH       = 6;

    // settling wait is base cycles shifted left by the select field
    localparam int         SETTLE_BASE_DEF  = 8;
    localparam int         SETTLE_CNT_W     = 11;

    typedef enum logic [1:0] {
        ST_ACTIVE   = 2'b00,
        ST_STANDBY  = 2'b01,
        ST_SETTLE   = 2'b11,
        ST_RST_WAIT = 2'b10
    } swm_state_e;

    // system control one: bit 7 standby, 6:4 settle select, 3 low speed
    typedef struct packed {
        logic       software_standby_bit;
        logic [2:0] settle_time_sel;
        logic       low_speed_on_bit;
        logic [2:0] unused;
    } swm_ctrl_one_s;
endpackage : swm_pkg
`default_nettype wire

// ==== src/swm_standby_ctrl.sv ====
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: sleep with standby set, low speed, timer clear
// RULE2: standby stops clock generator, state kept
// RULE3: exit only on irq, wake pin, reset
// RULE4: interrupt wake restarts clock generator first
// RULE5: wait settle time, then exception handling
// RULE6: resume medium speed if select bit set
// RULE7: global mask or disabled irq keeps standby
// RULE8: reset low restarts generator, high resumes
// RULE9: reset wake distributes clock without settling
// RULE10: reset source holds pin until stable
// RULE11: lcd gate zero stops, one runs
// RULE12: pwm one gate zero stops, one runs
// RULE13: watchdog gate zero stops, one runs
// RULE14: event counter gate zero stops, one runs
// RULE15: pwm two gate zero stops, one runs
// RULE16: detector gate, reserved without detector
// RULE17: gated peripheral keeps pending request asserted
// RULE18: frozen request keeps retriggering interrupts
// RULE19: software changes gating only with irqs off
// RULE20: gates reset to one, zero freezes peripheral
// RULE21: settle counter counts selected cycle number
module swm_standby_ctrl #(
    parameter int HAS_LVD     = 1,
    parameter int SETTLE_BASE = swm_pkg::SETTLE_BASE_DEF
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // apb slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic       pready,
    output var  logic       pslverr,
    // cpu and interrupt controller
    input  wire logic       sleep_exec,
    input  wire logic       timer_a_clock_top_bit,
    input  wire logic       cpu_irq_mask,
    input  wire logic       irq_a_en,
    input  wire logic       irq_b_en,
    input  wire logic [7:0] wakeup_en,
    // wake sources
    input  wire logic       ext_irq_a,
    input  wire logic       ext_irq_b,
    input  wire logic [7:0] wakeup_pins,
    input  wire logic       reset_pin_n,
    // power state outputs
    output var  logic       cpg_run,
    output var  logic       clk_dist,
    output var  logic       standby,
    output var  logic       medium_speed,
    output var  logic       irq_exc_start,
    output var  logic       rst_exc_start,
    // peripherals: lcd, pwm one, watchdog, event counter, pwm two, detector
    input  wire logic [swm_pkg::NUM_PERIPH-1:0] periph_irq_in,
    output var  logic [swm_pkg::NUM_PERIPH-1:0] periph_clk_en,
    output var  logic [swm_pkg::NUM_PERIPH-1:0] periph_irq_out
);
    import swm_pkg::*;

    swm_state_e              state_q, state_d;
    swm_ctrl_one_s           ctrl_one_q;
    logic [7:0]              ctrl_two_q;
    logic [7:0]              gate_q;
    logic [SETTLE_CNT_W-1:0] cnt_q;
    logic [SETTLE_CNT_W-1:0] cnt_d;

    // bus decode; no wait state, ready and read data are flopped during the setup phase
    wire setup_c  = psel & ~penable;
    wire access_c = psel & penable & pready;
    wire wr_c     = access_c & pwrite;
    wire sel_one  = (paddr == OFF_SYS_CTRL_ONE);
    wire sel_two  = (paddr == OFF_SYS_CTRL_TWO);
    wire sel_gate = (paddr == OFF_CLOCK_GATE);
    wire sel_stat = (paddr == OFF_STATUS);
    wire mapped_c = sel_one | sel_two | sel_gate | sel_stat;

    // reserved gate bits always read one; detector bit too if absent
    wire [7:0] gate_fix  = GATE_RSVD_MASK | ((HAS_LVD != 0) ? 8'h00 : 8'h80);
    wire [7:0] gate_wr   = pwdata[7:0] | gate_fix;
    wire [7:0] stat_word = {4'h0, cpg_run, medium_speed, state_q};
    wire [7:0] rd_byte   = sel_one  ? ctrl_one_q :
                           sel_two  ? ctrl_two_q :
                           sel_gate ? gate_q     :
                           sel_stat ? stat_word  : 8'h00;

    // wake sources; mask and per-source enables filter them
    wire src_irq  = (ext_irq_a & irq_a_en) | (ext_irq_b & irq_b_en)
                  | (|(wakeup_pins & wakeup_en));
    wire wake_irq = src_irq & ~cpu_irq_mask; // RULE3 RULE7
    wire enter_c  = sleep_exec & ctrl_one_q.software_standby_bit
                  & ~ctrl_one_q.low_speed_on_bit & ~timer_a_clock_top_bit; // RULE1
    wire [SETTLE_CNT_W-1:0] settle_len =
        SETTLE_CNT_W'(SETTLE_BASE) << ctrl_one_q.settle_time_sel; // RULE21

    // gates seen by the peripherals, lowest five bits then detector
    wire [NUM_PERIPH-1:0] gate_vec = {gate_q[LVD_GATE_BIT], gate_q[4:0]};

    // apb handshake and read data
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_c;
            pslverr <= setup_c & ~mapped_c;
            prdata  <= setup_c ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // software registers; status is read only and ignores writes
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_one_q <= swm_ctrl_one_s'(CTRL_ONE_RST);
            ctrl_two_q <= CTRL_TWO_RST;
            gate_q     <= CLOCK_GATE_RST; // RULE20
        end else begin
            if (wr_c && sel_one) begin
                ctrl_one_q <= swm_ctrl_one_s'({pwdata[7:3], 3'b000});
            end
            if (wr_c && sel_two) begin
                ctrl_two_q <= {7'h00, pwdata[MEDIUM_SPEED_BIT]};
            end
            if (wr_c && sel_gate) begin
                gate_q <= gate_wr; // RULE11 RULE12 RULE13 RULE14 RULE15 RULE16
            end
        end
    end

    // power state sequencing; reset pin wins over interrupts
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_ACTIVE: begin
                if (enter_c) begin
                    state_d = ST_STANDBY; // RULE1
                end
            end
            ST_STANDBY: begin
                if (!reset_pin_n) begin
                    state_d = ST_RST_WAIT; // RULE8
                end else if (wake_irq) begin
                    state_d = ST_SETTLE; // RULE4
                    cnt_d   = settle_len - SETTLE_CNT_W'(1);
                end
            end
            ST_SETTLE: begin
                if (!reset_pin_n) begin
                    state_d = ST_RST_WAIT;
                end else if (cnt_q == '0) begin
                    state_d = ST_ACTIVE; // RULE5
                end else begin
                    cnt_d = cnt_q - SETTLE_CNT_W'(1); // RULE21
                end
            end
            ST_RST_WAIT: begin
                // the reset source is trusted to release only when stable
                if (reset_pin_n) begin
                    state_d = ST_ACTIVE; // RULE10
                end
            end
        endcase
    end

    // state, counter and power outputs, all from flops
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q       <= ST_ACTIVE;
            cnt_q         <= '0;
            cpg_run       <= 1'b1;
            clk_dist      <= 1'b1;
            standby       <= 1'b0;
            irq_exc_start <= 1'b0;
            rst_exc_start <= 1'b0;
        end else begin
            state_q       <= state_d;
            cnt_q         <= cnt_d;
            cpg_run       <= (state_d != ST_STANDBY); // RULE2 RULE4
            clk_dist      <= (state_d == ST_ACTIVE) || (state_d == ST_RST_WAIT); // RULE9
            standby       <= (state_d != ST_ACTIVE);
            irq_exc_start <= (state_q == ST_SETTLE) && (state_d == ST_ACTIVE); // RULE5
            rst_exc_start <= (state_q == ST_RST_WAIT) && (state_d == ST_ACTIVE); // RULE8
        end
    end

    // speed is chosen at the moment of leaving standby only
    always_ff @(posedge clk) begin
        if (srst) begin
            medium_speed <= 1'b0;
        end else if (state_q == ST_SETTLE && state_d == ST_ACTIVE) begin
            medium_speed <= ctrl_two_q[MEDIUM_SPEED_BIT]; // RULE6
        end else if (state_q == ST_RST_WAIT && state_d == ST_ACTIVE) begin
            medium_speed <= 1'b0;
        end
    end

    // per-peripheral gating; a gated request is frozen, not withdrawn,
    // so it retriggers until software masks it
    for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
        always_ff @(posedge clk) begin
            if (srst) begin
                periph_clk_en[i]  <= 1'b1;
                periph_irq_out[i] <= 1'b0;
            end else begin
                periph_clk_en[i] <= gate_vec[i]; // RULE20
                if (gate_vec[i]) begin
                    periph_irq_out[i] <= periph_irq_in[i];
                end // RULE17 RULE18
            end
        end

        a_frozen_request: assert property ( // RULE17
            @(posedge clk) disable iff (srst)
            !gate_vec[i] |=> $stable(periph_irq_out[i]))
            else $error("gated peripheral request changed");

        a_irq_passthru: assert property ( // RULE20
            @(posedge clk) disable iff (srst)
            gate_vec[i] |=> periph_irq_out[i] == $past(periph_irq_in[i]))
            else $error("clocked peripheral request not forwarded");
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_enter_standby: assert property ( // RULE1
        state_q == ST_ACTIVE && enter_c |=> standby && !cpg_run ##1 standby)
        else $error("sleep did not enter standby");

    a_gen_stopped: assert property ( // RULE2
        state_q == ST_STANDBY |-> !cpg_run && !clk_dist && standby)
        else $error("clock running in standby");

    a_no_spurious_exit: assert property ( // RULE3
        state_q == ST_STANDBY && !wake_irq && reset_pin_n |=> state_q == ST_STANDBY)
        else $error("standby left without wake event");

    a_irq_restart: assert property ( // RULE4
        state_q == ST_STANDBY && wake_irq && reset_pin_n
        |=> cpg_run && !clk_dist && state_q == ST_SETTLE)
        else $error("interrupt wake did not restart generator");

    a_settle_load: assert property ( // RULE21
        $changed(state_q) && state_q == ST_SETTLE
        |-> cnt_q == $past(settle_len) - SETTLE_CNT_W'(1))
        else $error("settle counter loaded wrong");

    a_settle_exit: assert property ( // RULE5
        state_q == ST_SETTLE && cnt_q == '0 && reset_pin_n
        |=> irq_exc_start && clk_dist && !standby ##1 !irq_exc_start)
        else $error("settle end did not start exception");

    a_speed_choice: assert property ( // RULE6
        irq_exc_start |-> medium_speed == ctrl_two_q[MEDIUM_SPEED_BIT])
        else $error("wrong speed after wake");

    a_mask_holds: assert property ( // RULE7
        state_q == ST_STANDBY && cpu_irq_mask && reset_pin_n |=> standby && !cpg_run)
        else $error("masked interrupt left standby");

    a_reset_wake: assert property ( // RULE9
        state_q == ST_STANDBY && !reset_pin_n |=> cpg_run && clk_dist && !rst_exc_start)
        else $error("reset wake did not distribute clock");

    a_reset_release: assert property ( // RULE8
        state_q == ST_RST_WAIT && reset_pin_n |=> rst_exc_start && !standby)
        else $error("reset release did not start reset handling");

    a_gate_follow: assert property ( // RULE11
        ##1 periph_clk_en == $past(gate_vec))
        else $error("peripheral clock enable differs from gate");

    // reset pin overrides a running settle wait; clock is distributed in the next cycle
    a_settle_reset: assert property ( // RULE8
        state_q == ST_SETTLE && !reset_pin_n
        |=> state_q == ST_RST_WAIT && cpg_run && clk_dist && !irq_exc_start)
        else $error("reset pin ignored during settle");

    a_settle_hold: assert property ( // RULE5
        state_q == ST_SETTLE && cnt_q != '0 && reset_pin_n
        |=> state_q == ST_SETTLE && !clk_dist && standby)
        else $error("settle wait cut short");

    a_exc_pulse: assert property ( // RULE8
        rst_exc_start |=> !rst_exc_start)
        else $error("reset handling pulse too long");

    a_gate_reserved: assert property ( // RULE16
        (gate_q & gate_fix) == gate_fix)
        else $error("reserved gate bit cleared");

    // main scenarios the bench is expected to reach
    c_irq_wake: cover property (state_q == ST_SETTLE ##[1:1000] irq_exc_start);
    c_reset_wake: cover property (state_q == ST_RST_WAIT ##[1:100] rst_exc_start);
    c_medium: cover property (irq_exc_start && medium_speed);
    c_frozen: cover property (!periph_clk_en[0] && periph_irq_out[0]);
    c_reset_in_settle: cover property (state_q == ST_SETTLE && !reset_pin_n);
endmodule : swm_standby_ctrl
`default_nettype wire

// ==== src/swm_tb_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/swm_reset_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module swm_reset_source (
    // clock and command
    input  wire logic clk,
    input  wire logic cpg_run,
    input  wire logic press,
    // reset pin, active low
    output var  logic reset_pin_n
);
    logic pin_q  = 1'b1;
    int   hold_q = 0;
    assign reset_pin_n = pin_q;
    // low on command, high only after the restarted generator settled
    always @(posedge clk) begin
        if (press) begin
            pin_q  <= 1'b0;
            hold_q <= 6;
        end else if (hold_q > 0) begin
            hold_q <= cpg_run ? hold_q - 1 : hold_q;
        end else begin
            pin_q <= 1'b1;
        end
    end
endmodule // swm_reset_source
`default_nettype wire

// ==== tb/tb_swm_standby_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_swm_standby_ctrl;
    import swm_pkg::*;
    localparam int SB = 2;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, wakeup_en = 8'h00, wakeup_pins = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        pready, pslverr, err_q, sleep_exec = 1'b0, tmr_top = 1'b0, irq_mask = 1'b0;
    logic        irq_a_en = 1'b1, irq_b_en = 1'b0, ext_irq_a = 1'b0, ext_irq_b = 1'b0;
    logic        reset_pin_n, press = 1'b0, cpg_run, clk_dist, standby, medium_speed;
    logic        irq_exc_start, rst_exc_start;
    logic [5:0]  periph_irq_in = 6'h00, periph_clk_en, periph_irq_out;
    int          num_errors = 0, total_checks = 0, cycles = 0, n;

    swm_standby_ctrl #(.HAS_LVD(1), .SETTLE_BASE(SB)) uut (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .timer_a_clock_top_bit(tmr_top), .cpu_irq_mask(irq_mask),
        .irq_a_en(irq_a_en), .irq_b_en(irq_b_en), .wakeup_en(wakeup_en), .ext_irq_a(ext_irq_a),
        .ext_irq_b(ext_irq_b), .wakeup_pins(wakeup_pins), .reset_pin_n(reset_pin_n),
        .cpg_run(cpg_run), .clk_dist(clk_dist), .standby(standby), .medium_speed(medium_speed),
        .irq_exc_start(irq_exc_start), .rst_exc_start(rst_exc_start),
        .periph_irq_in(periph_irq_in), .periph_clk_en(periph_clk_en),
        .periph_irq_out(periph_irq_out));
    swm_reset_source partner (.clk(clk), .cpg_run(cpg_run), .press(press),
        .reset_pin_n(reset_pin_n));

    always #25 clk = ~clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %0t %s", $time, msg);
            num_errors++;
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask
    // one apb transfer; idle cycle after it so psel is never reassigned in one step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        ticks(1);
        penable <= 1'b1;
        do ticks(1); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        ticks(1);
    endtask
    task automatic go_sleep();
        sleep_exec <= 1'b1;
        ticks(1);
        sleep_exec <= 1'b0;
        ticks(2);
    endtask
    // wait out the settle phase and judge the resumed mode
    task automatic wake_check(input logic m);
        while (cpg_run !== 1'b1) ticks(1);
        check({31'h0, clk_dist}, 32'h0, "clock given out before settling");
        n = 0;
        while (irq_exc_start !== 1'b1) begin
            ticks(1);
            n++;
        end
        check(n, SB << 1, "settle length");
        check({30'h0, medium_speed, standby}, {30'h0, m, 1'b0}, "resume speed");
    endtask

    task automatic t_regs();
        xfer(1'b1, 8'h10, 8'h00);
        check({31'h0, err_q}, 32'h1, "unmapped write accepted");
        xfer(1'b0, OFF_CLOCK_GATE, 8'h00);
        check(rd_q, {24'h0, CLOCK_GATE_RST}, "gate reset value");
        xfer(1'b1, OFF_SYS_CTRL_ONE, 8'h9F);
        xfer(1'b0, OFF_SYS_CTRL_ONE, 8'h00);
        check(rd_q, 32'h00000098, "control one readback");
        xfer(1'b1, OFF_SYS_CTRL_TWO, 8'hFF);
        xfer(1'b0, OFF_SYS_CTRL_TWO, 8'h00);
        check(rd_q, 32'h00000001, "control two readback");
    endtask
    task automatic t_gate();
        for (int i = 0; i < NUM_PERIPH; i++) begin
            xfer(1'b1, OFF_CLOCK_GATE, ~(8'h01 << ((i == 5) ? LVD_GATE_BIT : i)));
            ticks(1);
            check({26'h0, periph_clk_en}, {26'h0, ~(6'h01 << i)}, "gate");
        end
        xfer(1'b1, OFF_CLOCK_GATE, 8'hFF);
        periph_irq_in <= 6'h3F;
        ticks(3);
        // gating with requests pending on purpose
        xfer(1'b1, OFF_CLOCK_GATE, 8'h00);
        periph_irq_in <= 6'h00;
        xfer(1'b0, OFF_CLOCK_GATE, 8'h00);
        check(rd_q, 32'h00000060, "gate readback");
        check({26'h0, periph_irq_out}, 32'h3F, "frozen requests");
        xfer(1'b1, OFF_CLOCK_GATE, 8'hFF);
        ticks(2);
        check({26'h0, periph_irq_out}, 32'h0, "requests follow again");
    endtask
    task automatic t_sleep();
        xfer(1'b1, OFF_SYS_CTRL_TWO, 8'h01);
        xfer(1'b1, OFF_SYS_CTRL_ONE, 8'h98);
        go_sleep();
        check({31'h0, standby}, 32'h0, "standby with low speed set");
        xfer(1'b1, OFF_SYS_CTRL_ONE, 8'h90);
        go_sleep();
        check({30'h0, standby, cpg_run}, 32'h2, "standby entry");
        xfer(1'b0, OFF_STATUS, 8'h00);
        check(rd_q, 32'h00000001, "status in standby");
        irq_mask <= 1'b1;
        ext_irq_a <= 1'b1;
        ext_irq_b <= 1'b1;
        ticks(6);
        check({30'h0, standby, cpg_run}, 32'h2, "masked request woke");
        irq_mask <= 1'b0;
        ext_irq_a <= 1'b0;
        ticks(6);
        check({30'h0, standby, cpg_run}, 32'h2, "disabled request woke");
        ext_irq_a <= 1'b1;
        wake_check(1'b1);
        ext_irq_a <= 1'b0;
        xfer(1'b1, OFF_SYS_CTRL_TWO, 8'h00);
        go_sleep();
        wakeup_en <= 8'h80;
        wakeup_pins <= 8'h80;
        wake_check(1'b0);
        wakeup_pins <= 8'h00;
    endtask
    task automatic t_rst();
        go_sleep();
        press <= 1'b1;
        ticks(1);
        press <= 1'b0;
        while (cpg_run !== 1'b1) ticks(1);
        check({30'h0, clk_dist, reset_pin_n}, 32'h2, "clock on reset wake");
        while (rst_exc_start !== 1'b1) ticks(1);
        check({30'h0, reset_pin_n, standby}, 32'h2, "reset resume");
    endtask
    // medium speed wake first, then a reset pin pulled low inside a long settle wait
    task automatic t_rst_settle();
        xfer(1'b1, OFF_SYS_CTRL_TWO, 8'h01);
        go_sleep();
        ext_irq_a <= 1'b1;
        wake_check(1'b1);
        ext_irq_a <= 1'b0;
        xfer(1'b1, OFF_SYS_CTRL_ONE, 8'hB0);
        go_sleep();
        ext_irq_a <= 1'b1;
        while (cpg_run !== 1'b1) ticks(1);
        press <= 1'b1;
        ext_irq_a <= 1'b0;
        ticks(1);
        press <= 1'b0;
        n = 0;
        while (rst_exc_start !== 1'b1) begin
            ticks(1);
            if (irq_exc_start === 1'b1) begin
                n++;
            end
        end
        check(n, 0, "interrupt handling after reset in settle");
        check({30'h0, medium_speed, standby}, 32'h0, "speed after reset wake");
    endtask

    initial begin
        ticks(20);
        srst <= 1'b0;
        ticks(1);
        t_regs();
        t_gate();
        t_sleep();
        t_rst();
        t_rst_settle();
        stop_test();
    end
endmodule // tb_swm_standby_ctrl
`default_nettype wire
